/* hdl/asp_uart.sv */
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module asp_uart import asp_pkg::*; #(
   parameter logic [15:0] HALF_DIV = ASP_HALF_DEF
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic rxd_in,
   output logic txd_out,
   output logic txd_oe_out,
   output logic rts_out,
   output logic irq_out
);
   ////////////////////////////////////////////////////////////////
   // state and wires

   asp_cfg_t ctrl_r;
   logic [15:0] baud_r;
   logic [5:0] stat_r;
   logic [5:0] stat_nxt;
   logic [5:0] mask_r;
   logic [7:0] rxbuf_r;
   logic rxfull_r;
   logic rts_r;
   logic wait_r;
   logic [31:0] rdata_r;
   logic [7:0] errcnt_r;
   logic [23:0] low_r;
   logic brk_seen_r;
   logic irq_r;

   logic req;
   logic hold;
   logic issue;
   logic fire;
   logic wr_fire;
   logic rd_fire;
   logic tx_start;
   logic rx_gate;
   logic [31:0] wmerged;
   logic [31:0] rmux;
   logic [5:0] events;
   logic [5:0] w1c;
   logic [15:0] frame_len;
   logic brk_at;

   logic tx_busy;
   logic tx_done;
   logic tx_line;
   logic [7:0] rx_data;
   logic rx_valid;
   logic rx_perr;
   logic rx_ferr;
   logic rx_busy;

   ////////////////////////////////////////////////////////////////
   // bus handshake

   // request present
   assign req = avs_read_in | avs_write_in;

   // a char write stalls while the line cannot take it
   assign hold = avs_write_in && (avs_address_in == ASP_REG_TXDATA) &&
                 (tx_busy || rts_r ||
                  (!ctrl_r.four_wire && rx_busy));

   // answer prepared when request seen
   assign issue = req && wait_r && !hold;

   // edge where master sees wait low
   assign fire = req && !wait_r;
   assign wr_fire = fire && avs_write_in;
   assign rd_fire = fire && avs_read_in;

   // byte-lane merge
   assign wmerged = asp_be(rmux, avs_writedata_in, avs_byteenable_in);

   // wait low one cycle per access
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= !issue;
      end
   end

   // read data with the answer
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_r <= 32'h0000_0000;
      end else if (issue && avs_read_in) begin
         rdata_r <= rmux;
      end
   end

   ////////////////////////////////////////////////////////////////
   // register read mux

   // unmapped reads zero
   always_comb begin
      rmux = 32'h0000_0000;
      case (avs_address_in)
         ASP_REG_CTRL: begin
            rmux[7:0] = ctrl_r;
         end
         ASP_REG_BAUD: begin
            rmux[15:0] = baud_r;
         end
         ASP_REG_RXDATA: begin
            rmux[7:0] = rxbuf_r;
         end
         ASP_REG_STAT: begin
            rmux[5:0] = stat_r;
         end
         ASP_REG_MASK: begin
            rmux[5:0] = mask_r;
         end
         ASP_REG_LINE: begin
            rmux[4:0] = {rxd_in, rxfull_r, rts_r, rx_busy, tx_busy};
         end
         ASP_REG_ERRCNT: begin
            rmux[7:0] = errcnt_r;
         end
         default: begin
            rmux = 32'h0000_0000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // configuration registers

   // frame format and wiring mode
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_r <= ASP_CTRL_RST;
      end else if (wr_fire && avs_address_in == ASP_REG_CTRL) begin
         ctrl_r <= wmerged[7:0];
      end
   end

   // half-bit divisor; zero is kept at one
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         baud_r <= HALF_DIV;
      end else if (wr_fire && avs_address_in == ASP_REG_BAUD) begin
         baud_r <= (wmerged[15:0] == 16'h0000) ? 16'h0001
                   : wmerged[15:0];
      end
   end

   // interrupt mask
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mask_r <= ASP_MASK_RST;
      end else if (wr_fire && avs_address_in == ASP_REG_MASK) begin
         mask_r <= wmerged[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////
   // transmit path

   // char write starts a frame
   assign tx_start = wr_fire && (avs_address_in == ASP_REG_TXDATA);

   // driver on from start to last stop
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rts_r <= 1'b0;
      end else begin
         rts_r <= tx_start || (tx_busy && !tx_done);
      end
   end

   assign txd_out = tx_line;
   assign txd_oe_out = rts_r; // tri-state when idle
   assign rts_out = rts_r;

   asp_tx u_tx (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .start_in(tx_start),
      .data_in(avs_writedata_in[7:0]),
      .cfg_in(ctrl_r),
      .div_in(baud_r),
      .txd_out(tx_line),
      .busy_out(tx_busy),
      .done_out(tx_done)
   );

   ////////////////////////////////////////////////////////////////
   // receive path

   // two-wire: echo ignored while sending
   assign rx_gate = ctrl_r.rx_en &&
                    (ctrl_r.four_wire || !rts_r);

   asp_rx u_rx (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .en_in(rx_gate),
      .rxd_in(rxd_in),
      .cfg_in(ctrl_r),
      .div_in(baud_r),
      .data_out(rx_data),
      .valid_out(rx_valid),
      .perr_out(rx_perr),
      .ferr_out(rx_ferr),
      .busy_out(rx_busy)
   );

   // holding register; new char wins
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rxbuf_r <= 8'h00;
         rxfull_r <= 1'b0;
      end else if (rx_valid) begin
         rxbuf_r <= rx_data;
         rxfull_r <= 1'b1;
      end else if (rd_fire && avs_address_in == ASP_REG_RXDATA) begin
         rxfull_r <= 1'b0;
      end
   end

   // saturating bad-frame count
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         errcnt_r <= 8'h00;
      end else if (rx_valid && (rx_perr || rx_ferr) &&
                   errcnt_r != 8'hff) begin
         errcnt_r <= errcnt_r + 8'h01;
      end else if (wr_fire && avs_address_in == ASP_REG_ERRCNT) begin
         errcnt_r <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////
   // break detection

   // half bits in a longest frame
   assign frame_len = 16'd24;
   assign brk_at = (low_r == 24'(frame_len) * 24'(baud_r));

   // space longer than a frame is a break
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         low_r <= 24'h000000;
         brk_seen_r <= 1'b0;
      end else if (rxd_in || !rx_gate) begin
         low_r <= 24'h000000;
         brk_seen_r <= 1'b0;
      end else if (low_r != 24'hffffff) begin
         low_r <= low_r + 24'h000001;
         if (brk_at) begin
            brk_seen_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // status and interrupt

   // events this cycle
   always_comb begin
      events = 6'h00;
      events[ASP_ST_TXDONE] = tx_done;
      events[ASP_ST_RXRDY] = rx_valid;
      events[ASP_ST_PERR] = rx_valid && rx_perr;
      events[ASP_ST_FERR] = rx_valid && rx_ferr;
      events[ASP_ST_OVR] = rx_valid && rxfull_r &&
                           !(rd_fire &&
                             avs_address_in == ASP_REG_RXDATA);
      events[ASP_ST_BRK] = brk_at && !brk_seen_r;
   end

   // write-one-to-clear strobes
   assign w1c = (wr_fire && avs_address_in == ASP_REG_STAT &&
                 avs_byteenable_in[0]) ? avs_writedata_in[5:0] : 6'h00;

   // set wins over clear
   assign stat_nxt = (stat_r & ~w1c) | events;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stat_r <= 6'h00;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   // level interrupt while an unmasked bit is set
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_nxt & mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////
   // outputs

   assign avs_waitrequest_out = wait_r;
   assign avs_readdata_out = rdata_r;
   assign irq_out = irq_r;

endmodule : asp_uart
`default_nettype wire

/* common/asp_pkg.sv */
// How it works
// - characters shift out and in serially
// - one start bit, then 5 to 8 data bits
// - stop length 1, 1.5 or 2 bits
// - parity bit between last data and stop
// - even, odd or no parity; receiver checks
// - both ends share one frame setup
// - rts enables line driver, else tri-state
// - drive the line only while sending
// - two-wire mode never sends and receives together
// - four-wire mode sends and receives concurrently
package asp_pkg;
   localparam int unsigned ASP_CLK_HZ = 100_000_000;
   localparam int unsigned ASP_BAUD_DEF = 9600;
   localparam logic [15:0] ASP_HALF_DEF =
      16'(ASP_CLK_HZ / (2 * ASP_BAUD_DEF));
   localparam logic [4:0] ASP_REG_CTRL = 5'h00;
   localparam logic [4:0] ASP_REG_BAUD = 5'h04;
   localparam logic [4:0] ASP_REG_TXDATA = 5'h08;
   localparam logic [4:0] ASP_REG_RXDATA = 5'h0c;
   localparam logic [4:0] ASP_REG_STAT = 5'h10;
   localparam logic [4:0] ASP_REG_MASK = 5'h14;
   localparam logic [4:0] ASP_REG_LINE = 5'h18;
   localparam logic [4:0] ASP_REG_ERRCNT = 5'h1c;
   localparam logic [7:0] ASP_CTRL_RST = 8'h83;
   localparam logic [5:0] ASP_MASK_RST = 6'h00;
   localparam int ASP_ST_TXDONE = 0;
   localparam int ASP_ST_RXRDY = 1;
   localparam int ASP_ST_PERR = 2;
   localparam int ASP_ST_FERR = 3;
   localparam int ASP_ST_OVR = 4;
   localparam int ASP_ST_BRK = 5;
   localparam logic [1:0] ASP_PAR_EVEN = 2'h1;
   localparam logic [1:0] ASP_PAR_ODD = 2'h2;
   typedef struct packed {
      logic rx_en;
      logic four_wire;
      logic [1:0] stop;
      logic [1:0] par;
      logic [1:0] dbits;
   } asp_cfg_t;
   typedef enum logic [4:0] {
      ASP_S_IDLE = 5'b00001,
      ASP_S_START = 5'b00010,
      ASP_S_DATA = 5'b00100,
      ASP_S_PAR = 5'b01000,
      ASP_S_STOP = 5'b10000
   } asp_state_t;
   function automatic logic [3:0] asp_nbits(asp_cfg_t c);
      return 4'h5 + {2'h0, c.dbits};
   endfunction : asp_nbits
   function automatic logic asp_par_on(asp_cfg_t c);
      return (c.par == ASP_PAR_EVEN) || (c.par == ASP_PAR_ODD);
   endfunction : asp_par_on
   // stop length in half bits, minus one
   function automatic logic [1:0] asp_stop_h(asp_cfg_t c);
      return (c.stop == 2'h0) ? 2'h1 : (c.stop == 2'h1) ? 2'h2 : 2'h3;
   endfunction : asp_stop_h
   function automatic logic [7:0] asp_mask(logic [7:0] d, asp_cfg_t c);
      return d & (8'hff >> (2'h3 - c.dbits));
   endfunction : asp_mask
   function automatic logic asp_par(logic [7:0] d, asp_cfg_t c);
      return (c.par == ASP_PAR_ODD) ? ~(^asp_mask(d, c)) : ^asp_mask(d, c);
   endfunction : asp_par
   function automatic logic [31:0] asp_be(logic [31:0] o, logic [31:0] n,
                                          logic [3:0] be);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = n[8*i +: 8];
         end
      end
      return r;
   endfunction : asp_be
endpackage : asp_pkg

/* hdl/asp_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_tx import asp_pkg::*; (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic start_in,
   input wire logic [7:0] data_in,
   input wire asp_cfg_t cfg_in,
   input wire logic [15:0] div_in,
   output logic txd_out,
   output logic busy_out,
   output logic done_out
);
   asp_state_t state_r;
   logic [15:0] tmr_r;
   logic [1:0] half_r;
   logic [3:0] bitn_r;
   logic [7:0] sh_r;
   logic par_r;
   // frame sequencer, half-bit timed
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r <= ASP_S_IDLE;
         txd_out <= 1'b1;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         tmr_r <= 16'h0000;
         half_r <= 2'h0;
         bitn_r <= 4'h0;
         sh_r <= 8'h00;
         par_r <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (state_r == ASP_S_IDLE) begin
            if (start_in) begin
               sh_r <= data_in;
               par_r <= asp_par(data_in, cfg_in);
               txd_out <= 1'b0; // start at space
               busy_out <= 1'b1;
               tmr_r <= div_in - 16'h0001;
               half_r <= 2'h1;
               state_r <= ASP_S_START;
            end
         end else if (tmr_r != 16'h0000) begin
            tmr_r <= tmr_r - 16'h0001;
         end else begin
            tmr_r <= div_in - 16'h0001;
            if (half_r != 2'h0) begin
               half_r <= half_r - 2'h1;
            end else begin
               half_r <= 2'h1;
               case (state_r)
                  ASP_S_START, ASP_S_DATA: begin
                     if (state_r == ASP_S_DATA &&
                         bitn_r == asp_nbits(cfg_in)) begin
                        if (asp_par_on(cfg_in)) begin
                           txd_out <= par_r;
                           state_r <= ASP_S_PAR;
                        end else begin
                           txd_out <= 1'b1;
                           half_r <= asp_stop_h(cfg_in);
                           state_r <= ASP_S_STOP;
                        end
                     end else begin
                        txd_out <= sh_r[0]; // lsb first
                        sh_r <= sh_r >> 1;
                        bitn_r <= (state_r == ASP_S_START) ? 4'h1
                                  : bitn_r + 4'h1;
                        state_r <= ASP_S_DATA;
                     end
                  end
                  ASP_S_PAR: begin
                     txd_out <= 1'b1; // stop at mark
                     half_r <= asp_stop_h(cfg_in);
                     state_r <= ASP_S_STOP;
                  end
                  default: begin
                     busy_out <= 1'b0;
                     done_out <= 1'b1;
                     state_r <= ASP_S_IDLE;
                  end
               endcase
            end
         end
      end
   end
endmodule : asp_tx
`default_nettype wire

/* hdl/asp_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_rx import asp_pkg::*; (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic en_in,
   input wire logic rxd_in,
   input wire asp_cfg_t cfg_in,
   input wire logic [15:0] div_in,
   output logic [7:0] data_out,
   output logic valid_out,
   output logic perr_out,
   output logic ferr_out,
   output logic busy_out
);
   asp_state_t state_r;
   logic [15:0] tmr_r;
   logic half_r;
   logic [3:0] bitn_r;
   logic [7:0] sh_r;
   logic pbit_r;
   logic rxd_q_r;
   logic [17:0] tail_r;
   logic [7:0] word;
   assign word = sh_r >> (2'h3 - cfg_in.dbits);
   // busy until the far stop bit is over
   assign busy_out = (state_r != ASP_S_IDLE) || valid_out ||
                     (tail_r != 18'h0);
   // mid-bit sampler
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r <= ASP_S_IDLE;
         tmr_r <= 16'h0000;
         half_r <= 1'b0;
         bitn_r <= 4'h0;
         sh_r <= 8'h00;
         pbit_r <= 1'b0;
         rxd_q_r <= 1'b1;
         tail_r <= 18'h0;
         data_out <= 8'h00;
         valid_out <= 1'b0;
         perr_out <= 1'b0;
         ferr_out <= 1'b0;
      end else begin
         valid_out <= 1'b0;
         rxd_q_r <= rxd_in;
         if (valid_out) begin
            tail_r <= 18'(div_in) * 18'(asp_stop_h(cfg_in));
         end else if (tail_r != 18'h0) begin
            tail_r <= tail_r - 18'h1;
         end
         if (!en_in) begin
            state_r <= ASP_S_IDLE;
         end else if (state_r == ASP_S_IDLE) begin
            if (rxd_q_r && !rxd_in) begin // mark to space
               tmr_r <= div_in - 16'h0001;
               half_r <= 1'b0;
               state_r <= ASP_S_START;
            end
         end else if (tmr_r != 16'h0000) begin
            tmr_r <= tmr_r - 16'h0001;
         end else begin
            tmr_r <= div_in - 16'h0001;
            if (half_r) begin
               half_r <= 1'b0;
            end else begin
               half_r <= 1'b1;
               case (state_r)
                  ASP_S_START: begin
                     bitn_r <= 4'h0;
                     state_r <= rxd_in ? ASP_S_IDLE : ASP_S_DATA;
                  end
                  ASP_S_DATA: begin
                     sh_r <= {rxd_in, sh_r[7:1]}; // lsb first
                     bitn_r <= bitn_r + 4'h1;
                     if (bitn_r + 4'h1 == asp_nbits(cfg_in)) begin
                        state_r <= asp_par_on(cfg_in) ? ASP_S_PAR
                                   : ASP_S_STOP;
                     end
                  end
                  ASP_S_PAR: begin
                     pbit_r <= rxd_in;
                     state_r <= ASP_S_STOP;
                  end
                  default: begin
                     data_out <= word;
                     valid_out <= 1'b1;
                     ferr_out <= !rxd_in;
                     perr_out <= asp_par_on(cfg_in) &&
                                 (pbit_r != asp_par(word, cfg_in));
                     state_r <= ASP_S_IDLE;
                  end
               endcase
            end
         end
      end
   end
endmodule : asp_rx
`default_nettype wire

/* sim/asp_uart_props.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_uart_props import asp_pkg::*; #(
   parameter logic [15:0] HALF_DIV = ASP_HALF_DEF
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic txd_out,
   input wire logic txd_oe_out,
   input wire logic rts_out
);
   int unsigned hi_cnt;
   // cycles in frame
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hi_cnt <= 0;
      end else begin
         hi_cnt <= rts_out ? hi_cnt + 1 : 0;
      end
   end
   default clocking dc @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   ////////////////////////////////////////////////////////////////////////
   // start: two cycles of space
   sequence s_space2;
      !txd_out ##1 !txd_out;
   endsequence
   property p_oe_rts;
      txd_oe_out == rts_out;
   endproperty
   property p_idle_mark;
      !rts_out |-> txd_out;
   endproperty
   property p_open;
      $rose(rts_out) |-> s_space2;
   endproperty
   property p_start_len;
      rts_out && hi_cnt < 2 * HALF_DIV |-> !txd_out;
   endproperty
   property p_close;
      $fell(rts_out) |-> txd_out && $past(txd_out);
   endproperty
   property p_min_len;
      $fell(rts_out) |-> hi_cnt >= 14 * HALF_DIV;
   endproperty
   property p_max_len;
      rts_out |-> hi_cnt <= 24 * HALF_DIV;
   endproperty
   property p_grid;
      rts_out && $changed(txd_out) |-> hi_cnt % HALF_DIV == 0;
   endproperty
   a_oe_rts: assert property (p_oe_rts)
      else $error("driver enable differs from rts");
   a_idle_mark: assert property (p_idle_mark)
      else $error("line not at mark while idle");
   a_open: assert property (p_open)
      else $error("frame does not open with space");
   a_start_len: assert property (p_start_len)
      else $error("start bit shorter than one bit time");
   a_close: assert property (p_close)
      else $error("frame does not close on mark");
   a_min_len: assert property (p_min_len)
      else $error("frame shorter than smallest format");
   a_max_len: assert property (p_max_len)
      else $error("driver held beyond longest frame");
   a_grid: assert property (p_grid)
      else $error("line changed off the half bit grid");
endmodule : asp_uart_props
bind asp_uart asp_uart_props #(.HALF_DIV(HALF_DIV)) u_props (
   .clk_in(clk_in),
   .rst_b_in(rst_b_in),
   .txd_out(txd_out),
   .txd_oe_out(txd_oe_out),
   .rts_out(rts_out)
);
`default_nettype wire

/* sim/asp_station.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_station import asp_pkg::*; #(
   parameter int HALF = 4
) (
   input wire logic clk_in,
   input wire logic line_in,
   input wire logic rts_in,
   input wire asp_cfg_t cfg_in,
   output logic drv_out,
   output logic oe_out,
   output logic [9:0] got_out,
   output logic got_stb_out
);
   logic [9:0] rbits;
   // hold a level for some half bits
   task automatic hold(input logic b, input int halves);
      drv_out <= b;
      repeat (halves * HALF) @(posedge clk_in);
   endtask : hold
   // send one frame in the shared format
   task automatic send(input logic [7:0] d, input logic bad_par,
                       input logic bad_stop);
      logic p;
      p = (cfg_in.par == ASP_PAR_ODD);
      while (rts_in) @(posedge clk_in);
      oe_out <= 1'b1;
      hold(1'b0, 2);
      for (int i = 0; i < 5 + cfg_in.dbits; i++) begin
         p = p ^ d[i];
         hold(d[i], 2);
      end
      if (asp_par_on(cfg_in)) begin
         hold(p ^ bad_par, 2);
      end
      hold(!bad_stop, 2 + (cfg_in.stop[1] ? 2 : int'(cfg_in.stop[0])));
      oe_out <= 1'b0;
      drv_out <= 1'b1;
   endtask : send
   // receiver, mid-bit sampling
   initial begin
      drv_out = 1'b1;
      oe_out = 1'b0;
      got_out = 10'h0;
      got_stb_out = 1'b0;
      forever begin
         @(posedge clk_in);
         if ((cfg_in.four_wire || !oe_out) && line_in === 1'b0) begin
            repeat (HALF - 1) @(posedge clk_in);
            rbits = 10'h0;
            for (int i = 0; i < 5 + cfg_in.dbits; i++) begin
               repeat (2 * HALF) @(posedge clk_in);
               rbits[i] = line_in;
            end
            if (asp_par_on(cfg_in)) begin
               repeat (2 * HALF) @(posedge clk_in);
               rbits[8] = line_in;
            end
            repeat (2 * HALF) @(posedge clk_in);
            rbits[9] = line_in;
            got_out <= rbits;
            got_stb_out <= 1'b1;
            @(posedge clk_in);
            got_stb_out <= 1'b0;
            while (line_in !== 1'b1) @(posedge clk_in);
         end
      end
   end
endmodule : asp_station
`default_nettype wire

/* sim/asp_uart_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_uart_tb import asp_pkg::*;;
   localparam logic [15:0] HD = 16'h0004;
   logic clk_in, rst_b_in, rd, wr, waitreq, rxd, txd, txd_oe, rts, irq;
   logic st_drv, st_oe, st_stb, line_w;
   logic [4:0] addr;
   logic [31:0] wdata, rdata;
   logic [3:0] be;
   logic [9:0] st_got;
   logic [7:0] d;
   logic [31:0] rd_q[$], rm_q[$];
   logic [9:0] tx_q[$];
   asp_cfg_t cfg, c;
   int fails, checks_done, cyc, t0;
   integer seed;
   // two wires share one pair, four wires split it; idle bias is mark
   assign line_w = txd_oe ? txd : (st_oe ? st_drv : 1'b1);
   assign rxd = cfg.four_wire ? (st_oe ? st_drv : 1'b1) : line_w;
   asp_uart #(.HALF_DIV(HD)) DUT (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdata), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .rxd_in(rxd), .txd_out(txd), .txd_oe_out(txd_oe), .rts_out(rts),
      .irq_out(irq));
   asp_station #(.HALF(int'(HD))) st (.clk_in(clk_in),
      .line_in(cfg.four_wire ? (txd_oe ? txd : 1'b1) : line_w),
      .rts_in(rts), .cfg_in(cfg), .drv_out(st_drv), .oe_out(st_oe),
      .got_out(st_got), .got_stb_out(st_stb));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      if (fails == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   // one bus access, held until wait low
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] dv, m);
      @(posedge clk_in);
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= dv;
      if (!w) begin
         rd_q.push_back(dv);
         rm_q.push_back(m);
      end
      do @(posedge clk_in); while (waitreq !== 1'b0);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task automatic wreg(input logic [4:0] a, input logic [31:0] dv);
      bus(1'b1, a, dv, 32'h0);
   endtask : wreg
   task automatic rreg(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, e, 32'hffffffff);
   endtask : rreg
   task automatic setcfg(input asp_cfg_t n);
      cfg = n;
      wreg(ASP_REG_CTRL, 32'(n));
   endtask : setcfg
   task automatic wait_irq();
      for (int n = 0; irq !== 1'b1 && n < 4000; n++) @(posedge clk_in);
      chk(32'(irq), 32'h1, "irq");
   endtask : wait_irq
   // expected frame
   function automatic logic [9:0] frame(input logic [7:0] v);
      logic [7:0] dm;
      logic p;
      dm = v & (8'hff >> (3 - cfg.dbits));
      p = (cfg.par == ASP_PAR_ODD) ? ~(^dm) : ^dm;
      if (cfg.par != ASP_PAR_EVEN && cfg.par != ASP_PAR_ODD) p = 1'b0;
      return {1'b1, p, dm};
   endfunction : frame
   ////////////////////////////////////////////////////////////////////////
   // clock, timeout and result watcher
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         wrap_up();
      end
      if (rd && waitreq === 1'b0 && rd_q.size() > 0) begin
         chk(rdata & rm_q[0], rd_q[0] & rm_q[0], "readdata");
         void'(rd_q.pop_front());
         void'(rm_q.pop_front());
      end
      if (st_stb && tx_q.size() > 0) begin
         chk(32'(st_got), 32'(tx_q.pop_front()), "line frame");
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b_in = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 5'h00;
      wdata = 32'h0;
      be = 4'hf;
      seed = 17;
      cfg = asp_cfg_t'(ASP_CTRL_RST);
      repeat (16) @(posedge clk_in);
      rst_b_in <= 1'b1;
      rreg(ASP_REG_CTRL, 32'(ASP_CTRL_RST));
      rreg(ASP_REG_BAUD, 32'(HD));
      rreg(ASP_REG_MASK, 32'(ASP_MASK_RST));
      chk(32'(txd), 32'h1, "idle line");
      // twelve frame formats: each data length with each parity, all three stop lengths
      wreg(ASP_REG_MASK, 32'h1);
      for (int i = 0; i < 12; i++) begin
         c = asp_cfg_t'(ASP_CTRL_RST);
         c.dbits = 2'(i % 4);
         c.par = 2'(i % 3);
         c.stop = 2'(i / 4);
         setcfg(c);
         d = 8'($random(seed));
         tx_q.push_back(frame(d));
         wreg(ASP_REG_TXDATA, 32'(d));
         wait_irq();
         rreg(ASP_REG_STAT, 32'h1);
         wreg(ASP_REG_STAT, 32'h3f);
         rreg(ASP_REG_STAT, 32'h0);
         chk(32'(irq), 32'h0, "irq cleared");
      end
      // rx: good, bad parity, bad stop
      c = asp_cfg_t'(ASP_CTRL_RST);
      c.par = ASP_PAR_EVEN;
      setcfg(c);
      wreg(ASP_REG_MASK, 32'h2);
      d = 8'($random(seed));
      st.send(d, 1'b0, 1'b0);
      wait_irq();
      rreg(ASP_REG_RXDATA, 32'(d));
      rreg(ASP_REG_STAT, 32'h2);
      wreg(ASP_REG_STAT, 32'h3f);
      st.send(8'h55, 1'b1, 1'b0);
      bus(1'b0, ASP_REG_STAT, 32'h4, 32'h4);
      st.send(8'h55, 1'b0, 1'b1);
      bus(1'b0, ASP_REG_STAT, 32'h8, 32'h8);
      rreg(ASP_REG_ERRCNT, 32'h2);
      wreg(ASP_REG_STAT, 32'h3f);
      // two wires: send waits for rx
      d = 8'($random(seed));
      tx_q.push_back(frame(d));
      fork
         st.send(8'h3c, 1'b0, 1'b0);
         begin
            repeat (4) @(posedge clk_in);
            t0 = cyc;
            wreg(ASP_REG_TXDATA, 32'(d));
            chk(32'(cyc - t0 >= 18 * HD), 32'h1, "send stall");
         end
      join
      rreg(ASP_REG_RXDATA, 32'h3c);
      wreg(ASP_REG_STAT, 32'h3f);
      wreg(ASP_REG_MASK, 32'h1);
      wait_irq();
      // four wires: both directions at once
      c.four_wire = 1'b1;
      setcfg(c);
      wreg(ASP_REG_STAT, 32'h3f);
      d = 8'($random(seed));
      tx_q.push_back(frame(d));
      fork
         st.send(8'ha5, 1'b0, 1'b0);
         wreg(ASP_REG_TXDATA, 32'(d));
      join
      wait_irq();
      rreg(ASP_REG_RXDATA, 32'ha5);
      repeat (10) @(posedge clk_in);
      chk(32'(tx_q.size()), 32'h0, "frames pending");
      wrap_up();
   end
endmodule : asp_uart_tb
`default_nettype wire
